/* File: fctl_pkg.sv */
// Constants, register map and state codes for the FIFO pin controller
package fctl_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and pin timing, figures in ns and derived cycle counts
    localparam int CLK_PERIOD_NS = 20;
    localparam int RS_SETUP_NS = 45;
    localparam int RS_LOW_NS = 50;
    localparam int RS_RECOVER_NS = 45;
    localparam int WR_LOW_NS = 35;
    localparam int WR_HOLD_NS = 5;
    localparam int RD_LOW_NS = 35;
    localparam int RD_RECOVER_NS = 15;
    localparam int RT_LOW_NS = 35;
    localparam int RT_RECOVER_NS = 45;

    // Least times, so round up to whole cycles
    localparam logic [7:0] RS_SETUP_CYC = 8'((RS_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RS_LOW_CYC = 8'((RS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RS_RECOVER_CYC =
        8'((RS_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WR_LOW_CYC = 8'((WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] WR_HOLD_CYC = 8'((WR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RD_LOW_CYC = 8'((RD_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RD_RECOVER_CYC =
        8'((RD_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RT_LOW_CYC = 8'((RT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] RT_RECOVER_CYC =
        8'((RT_RECOVER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    ////////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_CFG = 12'h004;
    localparam logic [11:0] REG_WDATA = 12'h008;
    localparam logic [11:0] REG_RDATA = 12'h00C;
    localparam logic [11:0] REG_STATUS = 12'h010;

    // Field positions
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_RETX_BIT = 1;
    localparam int CFG_XI_BIT = 0;
    localparam int CFG_FL_BIT = 1;
    localparam int RDATA_VALID_BIT = 31;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_INIT_BIT = 1;
    localparam int ST_EMPTY_N_BIT = 2;
    localparam int ST_FULL_N_BIT = 3;
    localparam int ST_HALF_N_BIT = 4;
    localparam int ST_RVALID_BIT = 5;
    localparam int ST_REFUSED_BIT = 6;

    // Values after reset
    localparam logic CFG_XI_RESET = 1'b0;
    localparam logic CFG_FL_RESET = 1'b1;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer states, one-hot
    typedef enum logic [11:0] {
        ST_IDLE = 12'h001,
        ST_RST_PRE = 12'h002,
        ST_RST_LOW = 12'h004,
        ST_RST_POST = 12'h008,
        ST_RT_LOW = 12'h010,
        ST_RT_POST = 12'h020,
        ST_WR_WAIT = 12'h040,
        ST_WR_LOW = 12'h080,
        ST_WR_HOLD = 12'h100,
        ST_RD_WAIT = 12'h200,
        ST_RD_LOW = 12'h400,
        ST_RD_HOLD = 12'h800
    } fctl_state_t;

endpackage

/* File: fctl_cycle_timer.sv */
// Down-counter that times each pin phase of the controller
`timescale 1ns/1ps
module fctl_cycle_timer #(
    parameter int CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [CNT_W-1:0] load_val,
    output logic done
);
    import fctl_pkg::*;

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;

    // Phase lasts load_val cycles: load sets val-1, done at zero
    always_comb begin
        nxt_cnt = cnt_ff;
        if (load) begin
            nxt_cnt = load_val - CNT_W'(1);
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cnt_ff <= '0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end

    assign done = (cnt_ff == '0);

    chk_timer_reload: assert property (@(posedge clk_sys) disable iff (!rst_n)
        load && load_val != '0 |=> cnt_ff == $past(load_val) - CNT_W'(1))
        else $error("timer did not reload");

endmodule // fctl_cycle_timer

/* File: fctl_host.sv */
// APB-controlled sequencer that drives the strobe pins of an external FIFO
`timescale 1ns/1ps

module fctl_host #(
    parameter int DATA_W = 9
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic fifo_reset_n,
    output logic write_strobe_n,
    output logic read_strobe_n,
    output logic first_load_or_retransmit,
    output logic expansion_input,
    output logic [DATA_W-1:0] data_in_lines,
    input wire logic [DATA_W-1:0] data_out_lines,
    input wire logic empty_flag_n,
    input wire logic full_flag_n,
    input wire logic expansion_out_or_half_full
);
    import fctl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State
    fctl_state_t state_ff, nxt_state;
    logic init_ff, nxt_init;
    logic refused_ff, nxt_refused;
    logic cfg_xi_ff, nxt_cfg_xi;
    logic cfg_fl_ff, nxt_cfg_fl;
    logic [DATA_W-1:0] wdata_ff, nxt_wdata;
    logic [DATA_W-1:0] rdata_ff, nxt_rdata;
    logic rd_valid_ff, nxt_rd_valid;
    logic rs_pin_ff, nxt_rs_pin;
    logic wr_pin_ff, nxt_wr_pin;
    logic rd_pin_ff, nxt_rd_pin;
    logic fl_pin_ff, nxt_fl_pin;
    logic [31:0] prdata_ff, nxt_prdata;
    logic timer_load;
    logic [7:0] timer_val;
    logic timer_done;
    logic bus_wr;
    logic mapped;
    logic idle;
    logic half_n;

    fctl_cycle_timer #(
        .CNT_W(8)
    ) u_timer (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(timer_load),
        .load_val(timer_val),
        .done(timer_done)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Bus decode; slave never stalls, so pready is constant high
    assign mapped = (paddr == REG_CTRL) || (paddr == REG_CFG) || (paddr == REG_WDATA)
        || (paddr == REG_RDATA) || (paddr == REG_STATUS);
    assign bus_wr = psel && penable && pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign idle = (state_ff == ST_IDLE);
    // Shared pin is only a half-full flag in single mode
    assign half_n = cfg_xi_ff ? 1'b1 : expansion_out_or_half_full;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer, bus register writes and pin levels
    always_comb begin
        nxt_state = state_ff;
        nxt_init = init_ff;
        nxt_refused = refused_ff;
        nxt_cfg_xi = cfg_xi_ff;
        nxt_cfg_fl = cfg_fl_ff;
        nxt_wdata = wdata_ff;
        nxt_rdata = rdata_ff;
        nxt_rd_valid = rd_valid_ff;
        timer_load = 1'b0;
        timer_val = 8'h01;

        // Commands start only from idle; others set the refused flag
        if (bus_wr) begin
            case (paddr)
                REG_CTRL: begin
                    if (pwdata[CTRL_RESET_BIT] && idle) begin
                        nxt_state = ST_RST_PRE;
                        timer_load = 1'b1;
                        timer_val = RS_SETUP_CYC;
                    end else if (pwdata[CTRL_RETX_BIT] && idle && init_ff && !cfg_xi_ff) begin
                        nxt_state = ST_RT_LOW;
                        timer_load = 1'b1;
                        timer_val = RT_LOW_CYC;
                    end else if (pwdata[CTRL_RESET_BIT] || pwdata[CTRL_RETX_BIT]) begin
                        nxt_refused = 1'b1;
                    end
                end
                REG_CFG: begin
                    // Mode levels frozen while busy so reset samples them stable
                    if (idle) begin
                        nxt_cfg_xi = pwdata[CFG_XI_BIT];
                        nxt_cfg_fl = pwdata[CFG_FL_BIT];
                    end else begin
                        nxt_refused = 1'b1;
                    end
                end
                REG_WDATA: begin
                    if (idle && init_ff) begin
                        nxt_wdata = pwdata[DATA_W-1:0];
                        nxt_state = ST_WR_WAIT;
                    end else begin
                        nxt_refused = 1'b1;
                    end
                end
                REG_RDATA: begin
                    if (idle && init_ff) begin
                        nxt_rd_valid = 1'b0;
                        nxt_state = ST_RD_WAIT;
                    end else begin
                        nxt_refused = 1'b1;
                    end
                end
                REG_STATUS: begin
                    // Write one to clear; the refusal below needs a REG_CTRL write, so it never meets a clear
                    if (pwdata[ST_REFUSED_BIT]) begin
                        nxt_refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
            if (!idle && paddr == REG_CTRL
                && (pwdata[CTRL_RESET_BIT] || pwdata[CTRL_RETX_BIT])) begin
                nxt_refused = 1'b1;
            end
        end

        case (state_ff)
            ST_IDLE: begin
            end
            ST_RST_PRE: begin
                if (timer_done) begin
                    nxt_state = ST_RST_LOW;
                    timer_load = 1'b1;
                    timer_val = RS_LOW_CYC;
                end
            end
            ST_RST_LOW: begin
                if (timer_done) begin
                    nxt_state = ST_RST_POST;
                    timer_load = 1'b1;
                    timer_val = RS_RECOVER_CYC;
                end
            end
            ST_RST_POST: begin
                if (timer_done) begin
                    nxt_state = ST_IDLE;
                    nxt_init = 1'b1;
                    nxt_rd_valid = 1'b0;
                end
            end
            ST_RT_LOW: begin
                if (timer_done) begin
                    nxt_state = ST_RT_POST;
                    timer_load = 1'b1;
                    timer_val = RT_RECOVER_CYC;
                end
            end
            ST_RT_POST: begin
                if (timer_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_WR_WAIT: begin
                // Level check of the flag avoids relying on its edges
                if (full_flag_n) begin
                    nxt_state = ST_WR_LOW;
                    timer_load = 1'b1;
                    timer_val = WR_LOW_CYC;
                end
            end
            ST_WR_LOW: begin
                if (timer_done) begin
                    nxt_state = ST_WR_HOLD;
                    timer_load = 1'b1;
                    timer_val = WR_HOLD_CYC;
                end
            end
            ST_WR_HOLD: begin
                if (timer_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_RD_WAIT: begin
                // Waiting for data here keeps the strobe high until empty rises
                if (empty_flag_n) begin
                    nxt_state = ST_RD_LOW;
                    timer_load = 1'b1;
                    timer_val = RD_LOW_CYC;
                end
            end
            ST_RD_LOW: begin
                if (timer_done) begin
                    nxt_rdata = data_out_lines;
                    nxt_rd_valid = 1'b1;
                    nxt_state = ST_RD_HOLD;
                    timer_load = 1'b1;
                    timer_val = RD_RECOVER_CYC;
                end
            end
            ST_RD_HOLD: begin
                if (timer_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase

        // Pin levels follow the next state so they come straight from flops
        nxt_rs_pin = (nxt_state != ST_RST_LOW);
        nxt_wr_pin = (nxt_state != ST_WR_LOW);
        nxt_rd_pin = (nxt_state != ST_RD_LOW);
        nxt_fl_pin = (nxt_state == ST_RT_LOW) ? 1'b0 : (nxt_cfg_xi ? nxt_cfg_fl : 1'b1);
    end

    // Read data is captured in the setup phase; access phase just presents it
    always_comb begin
        nxt_prdata = prdata_ff;
        if (psel && !penable) begin
            case (paddr)
                REG_CFG: nxt_prdata = {30'h0, cfg_fl_ff, cfg_xi_ff};
                REG_WDATA: nxt_prdata = {{(32 - DATA_W){1'b0}}, wdata_ff};
                REG_RDATA: nxt_prdata = {rd_valid_ff, {(31 - DATA_W){1'b0}}, rdata_ff};
                REG_STATUS: nxt_prdata = {25'h0, refused_ff, rd_valid_ff, half_n, full_flag_n,
                    empty_flag_n, init_ff, !idle};
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            init_ff <= 1'b0;
            refused_ff <= 1'b0;
            cfg_xi_ff <= CFG_XI_RESET;
            cfg_fl_ff <= CFG_FL_RESET;
            wdata_ff <= '0;
            rdata_ff <= '0;
            rd_valid_ff <= 1'b0;
            rs_pin_ff <= 1'b1;
            wr_pin_ff <= 1'b1;
            rd_pin_ff <= 1'b1;
            fl_pin_ff <= 1'b1;
            prdata_ff <= 32'h0000_0000;
        end else begin
            state_ff <= nxt_state;
            init_ff <= nxt_init;
            refused_ff <= nxt_refused;
            cfg_xi_ff <= nxt_cfg_xi;
            cfg_fl_ff <= nxt_cfg_fl;
            wdata_ff <= nxt_wdata;
            rdata_ff <= nxt_rdata;
            rd_valid_ff <= nxt_rd_valid;
            rs_pin_ff <= nxt_rs_pin;
            wr_pin_ff <= nxt_wr_pin;
            rd_pin_ff <= nxt_rd_pin;
            fl_pin_ff <= nxt_fl_pin;
            prdata_ff <= nxt_prdata;
        end
    end

    assign fifo_reset_n = rs_pin_ff;
    assign write_strobe_n = wr_pin_ff;
    assign read_strobe_n = rd_pin_ff;
    assign first_load_or_retransmit = fl_pin_ff;
    assign expansion_input = cfg_xi_ff;
    assign data_in_lines = wdata_ff;
    assign prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence seq_rs_low;
        (!fifo_reset_n && write_strobe_n && read_strobe_n) [*3];
    endsequence

    sequence seq_rs_recover;
        (fifo_reset_n && write_strobe_n && read_strobe_n) [*3];
    endsequence

    chk_reset_strobes: assert property (
        $fell(fifo_reset_n) |-> seq_rs_low ##1 seq_rs_recover)
        else $error("strobes not high around reset pulse");

    chk_rs_setup: assert property (
        $fell(fifo_reset_n) |-> $past(write_strobe_n, 3) && $past(read_strobe_n, 3))
        else $error("strobes not high before reset pulse");

    chk_no_early_op: assert property (
        !init_ff |-> write_strobe_n && read_strobe_n)
        else $error("strobe before first reset cycle");

    chk_wr_when_free: assert property (
        $fell(write_strobe_n) |-> $past(full_flag_n))
        else $error("write started while full");

    chk_wr_data_hold: assert property (
        !write_strobe_n ##1 write_strobe_n |-> $stable(data_in_lines) ##1 $stable(data_in_lines))
        else $error("write data moved around strobe rise");

    chk_wr_width: assert property (
        $fell(write_strobe_n) |-> !write_strobe_n [*2] ##1 write_strobe_n)
        else $error("write strobe width wrong");

    chk_rd_when_data: assert property (
        $fell(read_strobe_n) |-> $past(empty_flag_n))
        else $error("read started while empty");

    chk_rd_capture: assert property (
        $rose(read_strobe_n) |-> rd_valid_ff && rdata_ff == $past(data_out_lines))
        else $error("read word not captured at strobe rise");

    chk_retx_single: assert property (
        $fell(first_load_or_retransmit) |-> !expansion_input && fifo_reset_n && read_strobe_n
            ##1 !first_load_or_retransmit ##1 first_load_or_retransmit)
        else $error("bad retransmit pulse");

endmodule // fctl_host

/* File: fctl_fifo_model.sv */
// Behavioural model of the strobe-driven FIFO device on the controller's far side
`timescale 1ns/1ps
module fctl_fifo_model
    import fctl_pkg::*;
(
    input wire logic fifo_reset_n,
    input wire logic write_strobe_n,
    input wire logic read_strobe_n,
    input wire logic first_load_or_retransmit,
    input wire logic expansion_input,
    input wire logic [8:0] data_in_lines,
    output logic [8:0] data_out_lines,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic expansion_out_or_half_full,
    output logic [7:0] viol
);
    logic [8:0] mem [0:2047];
    logic [10:0] wptr = '0;
    logic [10:0] rptr = '0;
    logic [8:0] last_q = 9'h0AA;
    logic half_n = 1'b1;
    logic depth_mode = 1'b0;
    logic seen_rst = 1'b0;
    logic rs_was_low = 1'b0;
    logic wr_on = 1'b0;
    logic rd_on = 1'b0;
    int cnt = 0;
    int wr_total = 0;
    realtime t_rs = 0.0;
    realtime t_wr = -1.0e6;

    ////////////////////////////////////////////////////////////////////////////////
    // Power-up levels; floating outputs show the inverse of the last word
    initial begin
        viol = 8'h00;
        empty_flag_n = 1'b0;
        full_flag_n = 1'b1;
        data_out_lines = ~last_q;
    end

    // Reset cycle: strobes must stay high around both reset edges
    always @(negedge fifo_reset_n) begin
        if (!(read_strobe_n && write_strobe_n)) viol++;
        wptr = '0;
        rptr = '0;
        cnt = 0;
        wr_total = 0;
        empty_flag_n = 1'b0;
        full_flag_n = 1'b1;
        half_n = 1'b1;
        depth_mode = expansion_input;
        rs_was_low = 1'b1;
    end
    always @(posedge fifo_reset_n) begin
        if (!(read_strobe_n && write_strobe_n)) viol++;
        t_rs = $realtime;
        // Power-up rise from unknown is no reset cycle
        seen_rst = rs_was_low;
    end

    // Write: flags that fall do so at the strobe fall, the word lands at the rise
    always @(negedge write_strobe_n) begin
        if (!seen_rst || $realtime - t_rs < RS_RECOVER_NS) viol++;
        // Host must never lean on the delayed write-while-full case
        if (!full_flag_n) viol++;
        wr_on = full_flag_n;
        if (wr_on) begin
            cnt++;
            full_flag_n = (cnt != 2048);
            if (cnt >= 1025) half_n = 1'b0;
        end
    end
    always @(posedge write_strobe_n) begin
        t_wr = $realtime;
        if (wr_on) begin
            mem[wptr] = data_in_lines;
            wptr++;
            wr_total++;
            empty_flag_n = 1'b1;
        end
        wr_on = 1'b0;
    end
    // Data must not move too soon after the write rise
    always @(data_in_lines) begin
        if ($realtime - t_wr < WR_HOLD_NS) viol++;
    end

    // Read: word shown at the fall, pointer moves at the rise
    always @(negedge read_strobe_n) begin
        if (!seen_rst || $realtime - t_rs < RS_RECOVER_NS) viol++;
        if (!empty_flag_n) viol++;
        rd_on = empty_flag_n;
        if (rd_on) begin
            last_q = mem[rptr];
            data_out_lines = last_q;
            cnt--;
            empty_flag_n = (cnt != 0);
        end
    end
    always @(posedge read_strobe_n) begin
        if (rd_on) begin
            rptr++;
            full_flag_n = 1'b1;
            if (cnt <= 1024) half_n = 1'b1;
        end
        rd_on = 1'b0;
        data_out_lines = ~last_q;
    end

    // Retransmit in single mode only; valid for at most 2048 writes since reset
    always @(negedge first_load_or_retransmit) begin
        if (fifo_reset_n && !depth_mode && !expansion_input) begin
            if (!read_strobe_n) viol++;
            rptr = '0;
            cnt = wr_total;
            empty_flag_n = (cnt != 0);
            full_flag_n = (cnt != 2048);
            half_n = (cnt < 1025);
        end
    end

    // Shared pin carries the half-full flag in single mode
    assign expansion_out_or_half_full = depth_mode ? 1'b1 : half_n;
endmodule // fctl_fifo_model

/* File: tb_top.sv */
// Self-checking bench: APB master, FIFO device model and scenarios
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
    import fctl_pkg::*;
    logic clk_sys, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic fifo_reset_n, write_strobe_n, read_strobe_n, first_load_or_retransmit;
    logic expansion_input, empty_flag_n, full_flag_n, expansion_out_or_half_full;
    logic [8:0] data_in_lines, data_out_lines;
    logic [7:0] viol;
    int mismatches, checks, cyc;

    fctl_host i_fctl_host (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fifo_reset_n(fifo_reset_n), .write_strobe_n(write_strobe_n),
        .read_strobe_n(read_strobe_n), .first_load_or_retransmit(first_load_or_retransmit),
        .expansion_input(expansion_input), .data_in_lines(data_in_lines),
        .data_out_lines(data_out_lines), .empty_flag_n(empty_flag_n),
        .full_flag_n(full_flag_n), .expansion_out_or_half_full(expansion_out_or_half_full));
    fctl_fifo_model i_fctl_fifo_model (.fifo_reset_n(fifo_reset_n),
        .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
        .first_load_or_retransmit(first_load_or_retransmit), .expansion_input(expansion_input),
        .data_in_lines(data_in_lines), .data_out_lines(data_out_lines),
        .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
        .expansion_out_or_half_full(expansion_out_or_half_full), .viol(viol));

    ////////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 100000) begin
            mismatches++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks; one idle cycle between transfers keeps each strobe single-driven
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Busy only shows a cycle after the command, so skip one edge first
    task automatic wait_idle();
        int n;
        n = 0;
        @(posedge clk_sys);
        do begin
            apb(1'b0, REG_STATUS, 32'h0);
            n++;
        end while (q[ST_BUSY_BIT] !== 1'b0 && n < 100);
        `CHK("busy", 1'b0, q[ST_BUSY_BIT])
    endtask
    task automatic chk_status(input logic [6:0] e);
        apb(1'b0, REG_STATUS, 32'h0);
        `CHK("status", e, q[6:0])
    endtask
    task automatic fifo_wr(input logic [8:0] d);
        apb(1'b1, REG_WDATA, {23'h0, d});
        wait_idle();
    endtask
    task automatic fifo_rd(input logic [8:0] e);
        apb(1'b1, REG_RDATA, 32'h0);
        wait_idle();
        apb(1'b0, REG_RDATA, 32'h0);
        `CHK("rdata", {1'b1, 22'h0, e}, q)
    endtask
    task automatic cmd(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        wait_idle();
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_regs();
        `CHK("pins", 5'b11110, {fifo_reset_n, write_strobe_n, read_strobe_n,
            first_load_or_retransmit, expansion_input})
        apb(1'b0, REG_CFG, 32'h0);
        `CHK("cfg", 32'h2, q)
        cmd(REG_WDATA, 32'h5);
        chk_status(7'h58);
        apb(1'b1, REG_STATUS, 32'h40);
        apb(1'b0, 12'h014, 32'h0);
        `CHK("unmapped", 1'b1, err)
        $display("test regs done");
    endtask
    task automatic t_reset();
        apb(1'b1, REG_CTRL, 32'h1);
        apb(1'b1, REG_CFG, 32'h3);
        wait_idle();
        chk_status(7'h5A);
        apb(1'b0, REG_CFG, 32'h0);
        `CHK("cfg busy", 32'h2, q)
        apb(1'b1, REG_STATUS, 32'h40);
        $display("test reset done");
    endtask
    task automatic t_retx();
        fifo_wr(9'h1FF);
        fifo_wr(9'h000);
        fifo_wr(9'h0A5);
        chk_status(7'h1E);
        fifo_rd(9'h1FF);
        fifo_rd(9'h000);
        fifo_rd(9'h0A5);
        chk_status(7'h3A);
        cmd(REG_CTRL, 32'h2);
        chk_status(7'h3E);
        fifo_rd(9'h1FF);
        cmd(REG_CFG, 32'h3);
        `CHK("xi pin", 1'b1, expansion_input)
        `CHK("fl pin", 1'b1, first_load_or_retransmit)
        cmd(REG_CTRL, 32'h2);
        chk_status(7'h7E);
        cmd(REG_CFG, 32'h2);
        apb(1'b1, REG_STATUS, 32'h40);
        $display("test retransmit done");
    endtask
    task automatic t_fill();
        cmd(REG_CTRL, 32'h1);
        for (int i = 0; i < 2048; i++) begin
            fifo_wr(i[8:0]);
            if (i == 1023) `CHK("half 1024", 1'b1, expansion_out_or_half_full)
            if (i == 1024) `CHK("half 1025", 1'b0, expansion_out_or_half_full)
        end
        chk_status(7'h06);
        fifo_rd(9'h000);
        chk_status(7'h2E);
        fifo_wr(9'h1AA);
        for (int i = 1; i < 2048; i++) begin
            fifo_rd(i[8:0]);
            if (i == 1023) `CHK("half 1025", 1'b0, expansion_out_or_half_full)
            if (i == 1024) `CHK("half 1024", 1'b1, expansion_out_or_half_full)
        end
        fifo_rd(9'h1AA);
        chk_status(7'h3A);
        `CHK("model", 8'h00, viol)
        $display("test fill done");
    endtask

    task end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        mismatches = 0;
        checks = 0;
        cyc = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_regs();
        t_reset();
        t_retx();
        t_fill();
        end_of_test();
    end
endmodule // tb_top
